// [ucr_channel_regs.sv]
// Purpose: Register select and access decode for one serial channel.
// Assumes: Host strobes are one-cycle pulses synchronous to clk.
// Notes: Transmit bytes pass through a sixteen-word buffer.

`timescale 1ns/1ps

module ucr_channel_regs #(
  parameter int FIFO_DEPTH = ucr_pkg::TX_FIFO_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire ucr_pkg::ucr_req_s     req,
  input  wire logic                  fifo_summary_select_n,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  input  wire ucr_pkg::ucr_stat_s    stat,
  input  wire logic [7:0]            rx_data,
  output logic                       rx_ready,
  output logic [7:0]                 tx_data,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output logic                       tx_room,
  output ucr_pkg::ucr_cfg_s          cfg,
  output logic [7:0]                 fctl_data,
  output logic                       fctl_wr,
  input  wire logic                  irq_in,
  output logic                       irq_out
);

  ucr_pkg::ucr_cfg_s    cfg_q;
  ucr_pkg::ucr_target_e target;
  logic                 enh_map;
  logic                 div_map;
  logic                 enh_on;
  logic                 sel_rd;
  logic                 sel_wr;
  logic [7:0]           wr_keep;
  logic [7:0]           ist_mask;
  logic [7:0]           next_rd_data;
  logic                 tx_push;

  // ---------------------------------------------------------------
  // Map selection.
  // ---------------------------------------------------------------
  assign enh_map  = (cfg_q.lfmt == ucr_pkg::LFMT_ENH_KEY);
  assign div_map  = cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT] && !enh_map;
  assign enh_on   = cfg_q.efc[ucr_pkg::EFC_ENH_BIT];
  assign sel_rd   = clk_en && req.sel && req.rd;
  assign sel_wr   = clk_en && req.sel && req.wr;
  assign ist_mask = enh_on ? 8'hFF : ~ucr_pkg::IST_ENH_MASK;

  always_comb begin
    target = ucr_pkg::TGT_NONE;
    if (enh_map) begin
      case (req.addr)
        ucr_pkg::OFS_EFC:  target = ucr_pkg::TGT_EFC;
        ucr_pkg::OFS_LFMT: target = ucr_pkg::TGT_LFMT;
        ucr_pkg::OFS_RES1: target = ucr_pkg::TGT_RES1;
        ucr_pkg::OFS_RES2: target = ucr_pkg::TGT_RES2;
        ucr_pkg::OFS_PAU1: target = ucr_pkg::TGT_PAU1;
        ucr_pkg::OFS_PAU2: target = ucr_pkg::TGT_PAU2;
        default:           target = ucr_pkg::TGT_NONE;
      endcase
    end else if (div_map) begin
      case (req.addr)
        ucr_pkg::OFS_DIVL: target = ucr_pkg::TGT_DIVL;
        ucr_pkg::OFS_DIVH: target = ucr_pkg::TGT_DIVH;
        ucr_pkg::OFS_DIVF: target = enh_on ? ucr_pkg::TGT_DIVF : ucr_pkg::TGT_NONE;
        ucr_pkg::OFS_LFMT: target = ucr_pkg::TGT_LFMT;
        ucr_pkg::OFS_MCTL: target = ucr_pkg::TGT_MCTL;
        ucr_pkg::OFS_SCR:  target = ucr_pkg::TGT_SCR;
        default:           target = ucr_pkg::TGT_NONE;
      endcase
    end else begin
      case (req.addr)
        ucr_pkg::OFS_DATA:  target = ucr_pkg::TGT_DATA;
        ucr_pkg::OFS_IEN:   target = ucr_pkg::TGT_IEN;
        ucr_pkg::OFS_IST:   target = ucr_pkg::TGT_IST;
        ucr_pkg::OFS_LFMT:  target = ucr_pkg::TGT_LFMT;
        ucr_pkg::OFS_MCTL:  target = ucr_pkg::TGT_MCTL;
        ucr_pkg::OFS_LCOND: target = ucr_pkg::TGT_LCOND;
        ucr_pkg::OFS_MCOND: target = ucr_pkg::TGT_MCOND;
        ucr_pkg::OFS_SCR:   target = ucr_pkg::TGT_SCR;
        default:            target = ucr_pkg::TGT_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register writes.
  // ---------------------------------------------------------------
  always_comb begin
    wr_keep = 8'hFF;
    if (!enh_on && target == ucr_pkg::TGT_IEN) begin
      wr_keep = ~ucr_pkg::IEN_ENH_MASK;
    end else if (!enh_on && target == ucr_pkg::TGT_MCTL) begin
      wr_keep = ~ucr_pkg::MCTL_ENH_MASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= ucr_pkg::CFG_RST;
    end else if (sel_wr) begin
      case (target)
        ucr_pkg::TGT_IEN:  cfg_q.ien  <= req.wdata & wr_keep;
        ucr_pkg::TGT_LFMT: cfg_q.lfmt <= req.wdata;
        ucr_pkg::TGT_MCTL: cfg_q.mctl <= req.wdata & wr_keep;
        ucr_pkg::TGT_SCR:  cfg_q.scr  <= req.wdata;
        ucr_pkg::TGT_DIVL: cfg_q.divl <= req.wdata;
        ucr_pkg::TGT_DIVH: cfg_q.divh <= req.wdata;
        ucr_pkg::TGT_DIVF: cfg_q.divf <= req.wdata;
        ucr_pkg::TGT_RES1: cfg_q.res1 <= req.wdata;
        ucr_pkg::TGT_RES2: cfg_q.res2 <= req.wdata;
        ucr_pkg::TGT_PAU1: cfg_q.pau1 <= req.wdata;
        ucr_pkg::TGT_PAU2: cfg_q.pau2 <= req.wdata;
        ucr_pkg::TGT_EFC: begin
          cfg_q.efc <= req.wdata;
          if (!req.wdata[ucr_pkg::EFC_ENH_BIT]) begin
            cfg_q.ien  <= cfg_q.ien & ~ucr_pkg::IEN_ENH_MASK;
            cfg_q.mctl <= cfg_q.mctl & ~ucr_pkg::MCTL_ENH_MASK;
            cfg_q.divf <= ucr_pkg::RST_BYTE;
          end
        end
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  assign cfg = cfg_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fctl_wr   <= 1'b0;
      fctl_data <= ucr_pkg::RST_BYTE;
    end else if (clk_en) begin
      fctl_wr <= sel_wr && target == ucr_pkg::TGT_IST;
      if (sel_wr && target == ucr_pkg::TGT_IST) begin
        fctl_data <= req.wdata & (enh_on ? 8'hFF : ~ucr_pkg::FCTL_ENH_MASK);
      end
    end
  end

  // ---------------------------------------------------------------
  // Register reads.
  // ---------------------------------------------------------------
  always_comb begin
    case (target)
      ucr_pkg::TGT_DATA:  next_rd_data = rx_data;
      ucr_pkg::TGT_IEN:   next_rd_data = cfg_q.ien;
      ucr_pkg::TGT_IST:   next_rd_data = stat.isrc & ist_mask;
      ucr_pkg::TGT_LFMT:  next_rd_data = cfg_q.lfmt;
      ucr_pkg::TGT_MCTL:  next_rd_data = cfg_q.mctl;
      ucr_pkg::TGT_LCOND: next_rd_data = stat.lcond;
      ucr_pkg::TGT_MCOND: next_rd_data = stat.mcond;
      ucr_pkg::TGT_SCR:   next_rd_data = cfg_q.scr;
      ucr_pkg::TGT_DIVL:  next_rd_data = cfg_q.divl;
      ucr_pkg::TGT_DIVH:  next_rd_data = cfg_q.divh;
      ucr_pkg::TGT_DIVF:  next_rd_data = cfg_q.divf;
      ucr_pkg::TGT_EFC:   next_rd_data = cfg_q.efc;
      ucr_pkg::TGT_RES1:  next_rd_data = cfg_q.res1;
      ucr_pkg::TGT_RES2:  next_rd_data = cfg_q.res2;
      ucr_pkg::TGT_PAU1:  next_rd_data = cfg_q.pau1;
      ucr_pkg::TGT_PAU2:  next_rd_data = cfg_q.pau2;
      default:            next_rd_data = ucr_pkg::RST_BYTE;
    endcase
    if (!fifo_summary_select_n) begin
      next_rd_data = stat.fifo_ready_summary;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data  <= ucr_pkg::RST_BYTE;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= sel_rd;
      if (sel_rd) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // Only a true receive-data read consumes a byte.
  assign rx_ready = sel_rd && fifo_summary_select_n && target == ucr_pkg::TGT_DATA;

  // ---------------------------------------------------------------
  // Transmit buffer.
  // ---------------------------------------------------------------
  assign tx_push = sel_wr && target == ucr_pkg::TGT_DATA;

  ucr_fifo #(
    .WIDTH (ucr_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (tx_push),
    .in_ready  (tx_room),
    .in_data   (req.wdata),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // ---------------------------------------------------------------
  // Interrupt gate.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
    end else if (clk_en) begin
      irq_out <= irq_in && cfg_q.mctl[ucr_pkg::MCTL_IRQ_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_key_written;
    sel_wr && req.addr == ucr_pkg::OFS_LFMT && req.wdata == ucr_pkg::LFMT_ENH_KEY;
  endsequence

  sequence s_scr_write;
    sel_wr && req.addr == ucr_pkg::OFS_SCR && !enh_map;
  endsequence

  sequence s_scr_read;
    sel_rd && fifo_summary_select_n && req.addr == ucr_pkg::OFS_SCR && !enh_map;
  endsequence

  sequence s_efc_cleared;
    sel_wr && enh_map && req.addr == ucr_pkg::OFS_EFC && !req.wdata[ucr_pkg::EFC_ENH_BIT];
  endsequence

  a_chan_idle_hold: assert property (!req.sel |=> $stable(cfg_q))
    else $error("Registers changed while channel not selected.");
  a_rx_data_read: assert property (sel_rd && fifo_summary_select_n && req.addr == ucr_pkg::OFS_DATA
      && !cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT] |-> rx_ready ##1 (rd_valid && rd_data == $past(rx_data)))
    else $error("Receive data read returned wrong byte.");
  a_divl_write: assert property (sel_wr && req.addr == ucr_pkg::OFS_DIVL && div_map
      |=> cfg_q.divl == $past(req.wdata))
    else $error("Divisor low not written.");
  a_fctl_write: assert property (sel_wr && req.addr == ucr_pkg::OFS_IST
      && !cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT] |=> fctl_wr && $stable(cfg_q))
    else $error("FIFO control write not issued.");
  a_scr_roundtrip: assert property (s_scr_write ##1 s_scr_read |=> rd_data == $past(req.wdata, 2))
    else $error("Scratch byte did not read back.");
  a_efc_after_key: assert property (s_key_written ##1 (sel_wr && req.addr == ucr_pkg::OFS_EFC)
      |=> cfg_q.efc == $past(req.wdata))
    else $error("Enhanced feature byte not written after key.");
  a_fifo_ready_summary_any_addr: assert property (sel_rd && !fifo_summary_select_n
      |=> rd_valid && rd_data == $past(stat.fifo_ready_summary))
    else $error("FIFO summary not returned.");
  a_enh_bits_zero: assert property (!enh_on |-> (cfg_q.ien & ucr_pkg::IEN_ENH_MASK) == 8'h00
      && (cfg_q.mctl & ucr_pkg::MCTL_ENH_MASK) == 8'h00 && cfg_q.divf == 8'h00)
    else $error("Enhanced bits set while enhancement off.");
  a_divf_locked: assert property (sel_wr && req.addr == ucr_pkg::OFS_DIVF && div_map && !enh_on
      |=> $stable(cfg_q.divf))
    else $error("Fraction register written while locked.");
  a_irq_gate_off: assert property (!cfg_q.mctl[ucr_pkg::MCTL_IRQ_BIT] && clk_en |=> !irq_out)
    else $error("Interrupt passed with gate closed.");
  a_ro_write_ignored: assert property (sel_wr && req.addr == ucr_pkg::OFS_LCOND && !cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT]
      |=> $stable(cfg_q) && !fctl_wr)
    else $error("Read-only write had an effect.");
  a_frozen_regs: assert property (!clk_en |=> $stable(cfg_q) && $stable(rd_data) && $stable(irq_out))
    else $error("Registers changed while clock enable low.");
  a_rd_needs_sel: assert property (clk_en && !(req.sel && req.rd) |=> !rd_valid)
    else $error("Read answered without a selected read strobe.");
  a_tx_push: assert property (sel_wr && tx_room && req.addr == ucr_pkg::OFS_DATA
      && !cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT] |=> tx_valid)
    else $error("Transmit byte not buffered.");
  a_divh_write: assert property (sel_wr && req.addr == ucr_pkg::OFS_DIVH && div_map
      |=> cfg_q.divh == $past(req.wdata))
    else $error("Divisor high not written.");
  a_lcond_read: assert property (sel_rd && fifo_summary_select_n && req.addr == ucr_pkg::OFS_LCOND
      && !cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT] |=> rd_data == $past(stat.lcond))
    else $error("Line condition read returned wrong byte.");
  a_res1_write: assert property (sel_wr && enh_map && req.addr == ucr_pkg::OFS_RES1
      |=> cfg_q.res1 == $past(req.wdata))
    else $error("Flow character not written.");
  a_enh_low_none: assert property (sel_rd && fifo_summary_select_n && enh_map && req.addr == ucr_pkg::OFS_DATA
      |-> !rx_ready ##1 rd_data == 8'h00)
    else $error("Unmapped offset under key answered.");
  a_no_pop_summary: assert property (!fifo_summary_select_n |-> !rx_ready)
    else $error("Summary read consumed a receive byte.");
  a_isrc_masked: assert property (sel_rd && fifo_summary_select_n && req.addr == ucr_pkg::OFS_IST && !enh_on
      && !cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT] |=> (rd_data & ucr_pkg::IST_ENH_MASK) == 8'h00)
    else $error("Upper interrupt source bits visible.");
  a_fctl_masked: assert property (sel_wr && req.addr == ucr_pkg::OFS_IST && !enh_on
      && !cfg_q.lfmt[ucr_pkg::LFMT_DIV_BIT] |=> (fctl_data & ucr_pkg::FCTL_ENH_MASK) == 8'h00)
    else $error("Upper FIFO control bits passed.");
  a_efc_clears: assert property (s_efc_cleared |=> (cfg_q.ien & ucr_pkg::IEN_ENH_MASK) == 8'h00
      && (cfg_q.mctl & ucr_pkg::MCTL_ENH_MASK) == 8'h00 && cfg_q.divf == 8'h00)
    else $error("Enhanced bits kept after enhancement cleared.");
  a_divf_open: assert property (sel_wr && div_map && enh_on && req.addr == ucr_pkg::OFS_DIVF
      |=> cfg_q.divf == $past(req.wdata))
    else $error("Fraction register not written while open.");
  a_irq_gate_on: assert property (clk_en && irq_in && cfg_q.mctl[ucr_pkg::MCTL_IRQ_BIT] |=> irq_out)
    else $error("Interrupt blocked with gate open.");

endmodule // ucr_channel_regs

// [ucr_pkg.sv]
// Purpose: Shared constants and types for the channel register decode.
// Assumes: One channel; the host bus is synchronous to clk.

package ucr_pkg;

  // ---------------------------------------------------------------
  // Widths, offsets and field positions.
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 3;
  localparam int          DATA_W        = 8;
  localparam int          TX_FIFO_DEPTH = 16;

  localparam logic [2:0]  OFS_DATA  = 3'h0;
  localparam logic [2:0]  OFS_IEN   = 3'h1;
  localparam logic [2:0]  OFS_IST   = 3'h2;
  localparam logic [2:0]  OFS_LFMT  = 3'h3;
  localparam logic [2:0]  OFS_MCTL  = 3'h4;
  localparam logic [2:0]  OFS_LCOND = 3'h5;
  localparam logic [2:0]  OFS_MCOND = 3'h6;
  localparam logic [2:0]  OFS_SCR   = 3'h7;
  localparam logic [2:0]  OFS_DIVL  = 3'h0;
  localparam logic [2:0]  OFS_DIVH  = 3'h1;
  localparam logic [2:0]  OFS_DIVF  = 3'h2;
  localparam logic [2:0]  OFS_EFC   = 3'h2;
  localparam logic [2:0]  OFS_RES1  = 3'h4;
  localparam logic [2:0]  OFS_RES2  = 3'h5;
  localparam logic [2:0]  OFS_PAU1  = 3'h6;
  localparam logic [2:0]  OFS_PAU2  = 3'h7;

  localparam logic [7:0]  LFMT_ENH_KEY   = 8'hBF;
  localparam int          LFMT_DIV_BIT   = 7;
  localparam int          EFC_ENH_BIT    = 4;
  localparam int          MCTL_IRQ_BIT   = 3;
  localparam logic [7:0]  IEN_ENH_MASK   = 8'hF0;
  localparam logic [7:0]  IST_ENH_MASK   = 8'h30;
  localparam logic [7:0]  FCTL_ENH_MASK  = 8'h30;
  localparam logic [7:0]  MCTL_ENH_MASK  = 8'hE0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;

  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    TGT_NONE  = 5'h00,
    TGT_DATA  = 5'h01,
    TGT_IEN   = 5'h02,
    TGT_IST   = 5'h03,
    TGT_LFMT  = 5'h04,
    TGT_MCTL  = 5'h05,
    TGT_LCOND = 5'h06,
    TGT_MCOND = 5'h07,
    TGT_SCR   = 5'h08,
    TGT_DIVL  = 5'h09,
    TGT_DIVH  = 5'h0A,
    TGT_DIVF  = 5'h0B,
    TGT_EFC   = 5'h0C,
    TGT_RES1  = 5'h0D,
    TGT_RES2  = 5'h0E,
    TGT_PAU1  = 5'h0F,
    TGT_PAU2  = 5'h10
  } ucr_target_e;

  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] lfmt;
    logic [7:0] mctl;
    logic [7:0] divl;
    logic [7:0] divh;
    logic [7:0] divf;
    logic [7:0] efc;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [7:0] pau1;
    logic [7:0] pau2;
    logic [7:0] scr;
  } ucr_cfg_s;

  typedef struct packed {
    logic [7:0] isrc;
    logic [7:0] lcond;
    logic [7:0] mcond;
    logic [7:0] fifo_ready_summary;
  } ucr_stat_s;

  typedef struct packed {
    logic             sel;
    logic             rd;
    logic             wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ucr_req_s;

  localparam ucr_cfg_s    CFG_RST = '0;

endpackage

// [ucr_fifo.sv]
// Purpose: Parameterised first-in first-out buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two, at least two.
// Notes: Clock enable low freezes all state.

`timescale 1ns/1ps

module ucr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // ---------------------------------------------------------------
  // Full and empty flags from the wrap bit of each pointer.
  // ---------------------------------------------------------------
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule // ucr_fifo

// [ucr_host_model.sv]
// Purpose: Host bus model that performs register reads and writes on the channel.
// Assumes: Strobes are one-cycle pulses launched 1 ns after a rising edge.
// Notes: Between accesses the address and data lines carry a changing filler pattern.

`timescale 1ns/1ps

module ucr_host_model (
  input  wire logic         clk,
  input  wire logic [7:0]   rd_data,
  input  wire logic         rd_valid,
  output ucr_pkg::ucr_req_s req
);
  logic       chan_sel;
  logic [7:0] filler;

  initial begin
    chan_sel = 1'b1;
    filler   = 8'h5A;
    req      = '0;
  end

  // ---------------------------------------------------------------
  // Bus cycles.
  // ---------------------------------------------------------------
  // Released lines take the inverted filler, whatever the last access drove.
  task automatic idle();
    filler    = ~filler;
    req.sel   = 1'b0;
    req.rd    = 1'b0;
    req.wr    = 1'b0;
    req.addr  = filler[2:0];
    req.wdata = filler;
  endtask

  task automatic wr(input logic [2:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    req.sel   = chan_sel;
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = data;
    @(posedge clk);
    #1;
    idle();
  endtask

  // A write followed in the very next cycle by a second access.
  task automatic wr_next(input logic [2:0] a1, input logic [7:0] d1, input logic rd2,
                         input logic [2:0] a2, input logic [7:0] d2,
                         output logic [7:0] data, output logic valid);
    @(posedge clk);
    #1;
    req.sel   = chan_sel;
    req.wr    = 1'b1;
    req.addr  = a1;
    req.wdata = d1;
    @(posedge clk);
    #1;
    req.wr    = !rd2;
    req.rd    = rd2;
    req.addr  = a2;
    req.wdata = d2;
    @(posedge clk);
    #1;
    data  = rd_data;
    valid = rd_valid;
    idle();
  endtask

  task automatic rd(input logic [2:0] addr, output logic [7:0] data, output logic valid);
    @(posedge clk);
    #1;
    req.sel  = chan_sel;
    req.rd   = 1'b1;
    req.addr = addr;
    @(posedge clk);
    #1;
    data  = rd_data;
    valid = rd_valid;
    idle();
  endtask

endmodule // ucr_host_model

// [ucr_channel_regs_tb.sv]
// Purpose: Self-checking bench for the channel register decode.
// Assumes: Host model drives the bus; status inputs are held constant.
// Notes: Counts comparisons and mismatches and ends in print_verdict.

`timescale 1ns/1ps

module ucr_channel_regs_tb;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              clk_en = 1'b1;
  logic              fifo_summary_select_n = 1'b1;
  logic              tx_ready = 1'b0;
  logic              irq_in = 1'b0;
  logic [7:0]        rx_data = 8'hC3;
  ucr_pkg::ucr_stat_s stat = '{isrc: 8'hFF, lcond: 8'h61, mcond: 8'h9C, fifo_ready_summary: 8'h3C};
  ucr_pkg::ucr_req_s req;
  ucr_pkg::ucr_cfg_s cfg;
  logic [7:0]        rd_data;
  logic [7:0]        tx_data;
  logic [7:0]        fctl_data;
  logic              rd_valid;
  logic              rx_ready;
  logic              tx_valid;
  logic              tx_room;
  logic              fctl_wr;
  logic              irq_out;
  int                n_fail = 0;
  int                n_checks = 0;
  int                n_pop = 0;
  int                n_fctl = 0;
  int                cycles = 0;
  logic [7:0]        bb_data;
  logic              bb_valid;

  always #2.5 clk = ~clk;

  ucr_channel_regs #(.FIFO_DEPTH(16)) DUT (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
    .fifo_summary_select_n(fifo_summary_select_n), .rd_data(rd_data), .rd_valid(rd_valid),
    .stat(stat), .rx_data(rx_data), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_room(tx_room), .cfg(cfg), .fctl_data(fctl_data), .fctl_wr(fctl_wr),
    .irq_in(irq_in), .irq_out(irq_out)
  );

  ucr_host_model host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));

  // ---------------------------------------------------------------
  // Checking and reporting.
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t ns: got 0x%02h expected 0x%02h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t ns: got 0x%01h expected 0x%01h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [2:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(addr, d, v);
    chk1(v, 1'b1);
    chk8(d, exp);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Counts pops, control pulses and cycles; a hang ends the run.
  always @(posedge clk) begin
    cycles++;
    if (rx_ready === 1'b1) n_pop++;
    if (fctl_wr === 1'b1) n_fctl++;
    if (cycles >= 5000) begin
      n_fail++;
      $display("timeout at %0t ns", $time);
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk1(tx_valid, 1'b0);
    chk1(tx_room, 1'b1);
    rdc(3'h7, 8'h00);
    done("reset");
    host.wr_next(3'h7, 8'hA5, 1'b1, 3'h7, 8'h00, bb_data, bb_valid);
    chk1(bb_valid, 1'b1);
    chk8(bb_data, 8'hA5);
    host.wr(3'h3, 8'h03);
    rdc(3'h3, 8'h03);
    host.wr(3'h1, 8'hFF);
    rdc(3'h1, 8'h0F);
    host.wr(3'h4, 8'hF7);
    rdc(3'h4, 8'h17);
    rdc(3'h2, 8'hCF);
    host.wr(3'h5, 8'h11);
    rdc(3'h5, 8'h61);
    rdc(3'h6, 8'h9C);
    host.wr(3'h2, 8'hFF);
    chk8(fctl_data, 8'hCF);
    chk1(fctl_wr, 1'b1);
    @(posedge clk);
    #1;
    chk8(8'(n_fctl), 8'h01);
    chk8(8'(n_pop), 8'h00);
    rdc(3'h0, 8'hC3);
    chk8(8'(n_pop), 8'h01);
    host.chan_sel = 1'b0;
    host.wr(3'h7, 8'h00);
    host.chan_sel = 1'b1;
    clk_en = 1'b0;
    host.wr(3'h7, 8'h00);
    clk_en = 1'b1;
    rdc(3'h7, 8'hA5);
    done("normal map");
    host.wr(3'h3, 8'h80);
    host.wr(3'h0, 8'h12);
    host.wr(3'h1, 8'h34);
    host.wr(3'h2, 8'h56);
    rdc(3'h0, 8'h12);
    rdc(3'h1, 8'h34);
    chk8(cfg.divl, 8'h12);
    rdc(3'h2, 8'h00);
    chk8(cfg.divf, 8'h00);
    rdc(3'h5, 8'h00);
    done("divisor");
    host.wr_next(3'h3, 8'hBF, 1'b0, 3'h2, 8'h10, bb_data, bb_valid);
    rdc(3'h2, 8'h10);
    for (int i = 4; i < 8; i++) host.wr(3'(i), 8'(8'h70 + i));
    for (int i = 4; i < 8; i++) rdc(3'(i), 8'(8'h70 + i));
    rdc(3'h0, 8'h00);
    rdc(3'h3, 8'hBF);
    host.wr(3'h3, 8'h80);
    host.wr(3'h2, 8'h56);
    rdc(3'h2, 8'h56);
    host.wr(3'h3, 8'h00);
    rdc(3'h1, 8'h0F);
    rdc(3'h7, 8'hA5);
    host.wr(3'h1, 8'hFF);
    rdc(3'h1, 8'hFF);
    host.wr(3'h4, 8'hF7);
    rdc(3'h4, 8'hF7);
    rdc(3'h2, 8'hFF);
    host.wr(3'h2, 8'hFF);
    chk8(fctl_data, 8'hFF);
    host.wr(3'h3, 8'hBF);
    host.wr(3'h2, 8'h00);
    host.wr(3'h3, 8'h00);
    rdc(3'h1, 8'h0F);
    rdc(3'h4, 8'h17);
    chk8(cfg.divf, 8'h00);
    done("enhanced");
    fifo_summary_select_n = 1'b0;
    for (int i = 0; i < 8; i++) rdc(3'(i), 8'h3C);
    chk8(8'(n_pop), 8'h01);
    fifo_summary_select_n = 1'b1;
    done("summary");
    irq_in = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk1(irq_out, 1'b0);
    host.wr(3'h4, 8'h08);
    @(posedge clk);
    #1;
    chk1(irq_out, 1'b1);
    irq_in = 1'b0;
    @(posedge clk);
    #1;
    chk1(irq_out, 1'b0);
    done("interrupt gate");
    for (int i = 0; i < 16; i++) host.wr(3'h0, 8'(8'h40 + i));
    chk1(tx_room, 1'b0);
    host.wr(3'h0, 8'hEE);
    tx_ready = 1'b1;
    for (int i = 0; i < 16; i++) begin
      chk1(tx_valid, 1'b1);
      chk8(tx_data, 8'(8'h40 + i));
      @(posedge clk);
      #1;
    end
    tx_ready = 1'b0;
    chk1(tx_valid, 1'b0);
    chk1(tx_room, 1'b1);
    done("transmit buffer");
    print_verdict();
  end

endmodule // ucr_channel_regs_tb
